// ### include/memory_to_stream_ctrl_defs.vh
// Offsets, fields, reset values and timing counts of the read channel control block
`ifndef MEMORY_TO_STREAM_CTRL_DEFS_VH
`define MEMORY_TO_STREAM_CTRL_DEFS_VH
`define OFF_READ_CTRL 8'h00
`define OFF_READ_STAT 8'h04
`define OFF_WRITE_CTRL 8'h30
`define OFF_IRQ_STATUS 8'h60
`define OFF_IRQ_MASK 8'h64
`define OFF_CONFIG 8'h68
`define BIT_RUN 0
`define BIT_RSVD_ONE 1
`define BIT_SOFT_RESET 2
`define BIT_FIXED_ADDR 3
`define BIT_HALTED 0
`define BIT_IDLE 1
`define BIT_ERROR 4
`define CTRL_RESET 32'h0000_0002
`define STAT_RESET 32'h0000_0001
`define IRQ_HALTED 0
`define IRQ_STARTED 1
`define IRQ_ERROR 2
`define IRQ_RESET_DONE 3
`define IRQ_WIDTH 4
`define CFG_DIRECT 0
`define CFG_MULTI 1
`define BURST_INCR 2'h1
`define BURST_FIXED 2'h0
`define RESET_HOLD_NS 64
`define CLK_PERIOD_NS 8
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### hdl/reset_sequencer.v
// Graceful engine-wide soft reset sequencer
`timescale 1ns/1ps
`include "memory_to_stream_ctrl_defs.vh"
module reset_sequencer
(
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request and engine state
  input wire request,
  input wire engineIdle,
  // Sequence outputs
  output reg inProgress,
  output reg engineReset,
  output reg done
);
  localparam S_IDLE = 2'd0;
  localparam S_DRAIN = 2'd1;
  localparam S_HOLD = 2'd2;
  localparam integer HOLD_LAST = `RESET_HOLD_CYCLES - 1;
  reg [1:0] state;
  reg [3:0] holdCount;
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      holdCount <= 4'h0;
      inProgress <= 1'b0;
      engineReset <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (request)
          begin
            state <= S_DRAIN;
            inProgress <= 1'b1;
          end
        end
        S_DRAIN:
        begin
          if (engineIdle)
          begin
            state <= S_HOLD;
            engineReset <= 1'b1;
            holdCount <= 4'h0;
          end
        end
        S_HOLD:
        begin
          if (holdCount == HOLD_LAST[3:0])
          begin
            state <= S_IDLE;
            engineReset <= 1'b0;
            inProgress <= 1'b0;
            done <= 1'b1;
          end
          else
          begin
            holdCount <= holdCount + 4'h1;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hdl/memory_to_stream_channel_control.v
// Read channel control bits 0 to 3 with register slave, halt and soft reset
`timescale 1ns/1ps
`include "memory_to_stream_ctrl_defs.vh"
// Overview of operation
// - Clearing run stops new work; halt only after current operation ends.
// - Chained mode: finish commands, may cut stream, write back descriptors first.
// - Direct mode: finish commands and transfers; stream may end early.
// - Halted status flag reads 1 once the engine has come to rest.
// - Any detected error clears run by hardware.
// - Writing run 1 starts work; halted drops to 0 when work begins.
// - Control bit 1 ignores writes and always reads 1.
// - Writing 1 to bit 2 starts a graceful soft reset.
// - Soft reset from either channel control resets the whole engine.
// - After soft reset all registers hold their reset values; the interrupt status then has the reset-done bit set.
// - Soft reset bit reads 1 during reset, 0 otherwise.
// - Fixed-address bit set makes reads use fixed AXI4 bursts.
// - Fixed-address bit is ignored in multichannel or direct mode.
// - Read channel control sits at offset zero in both modes.
module memory_to_stream_channel_control
(
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Engine data path
  input wire engineBusy,
  input wire descUpdatePending,
  input wire errorDetected,
  input wire writeChanReset,
  output reg runEnable,
  output reg flushRequest,
  output reg [1:0] readBurstType,
  output reg engineReset,
  // Interrupt
  output reg irq
);
  reg readRun;
  reg fixedAddr;
  reg halted;
  reg errorFlag;
  reg [31:0] writeCtrl;
  reg [`IRQ_WIDTH-1:0] irqStatus;
  reg [`IRQ_WIDTH-1:0] irqMask;
  reg directMode;
  reg multiChannel;
  reg ackPending;
  wire rstInProgress;
  wire rstPulse;
  wire rstDone;
  wire softReset;
  wire engineIdle;
  wire wrCycle;
  wire [31:0] wdata;
  reg [`IRQ_WIDTH-1:0] irqEvents;
  reg next_readRun;
  wire drainDone;
  wire [31:0] laneBits;
  localparam [31:0] CTRL_DEFAULT = `CTRL_RESET;

  function [31:0] laneMask;
    input [3:0] be;
    begin
      laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // One wait state per access; the answer is registered
  assign waitrequest = (read | write) & ~ackPending;
  assign wrCycle = write & ackPending;
  assign wdata = writedata & laneMask(byteenable);
  assign engineIdle = ~engineBusy & ~descUpdatePending;
  assign laneBits = laneMask(byteenable);
  // Idle only counts once the data path can no longer start new work
  assign drainDone = engineIdle & ~runEnable;
  assign softReset = (wrCycle && address == `OFF_READ_CTRL && byteenable[0]
      && writedata[`BIT_SOFT_RESET])
    || (wrCycle && address == `OFF_WRITE_CTRL && byteenable[0]
      && writedata[`BIT_SOFT_RESET])
    || writeChanReset;

  reset_sequencer seq
  (
    .clk(clk),
    .rst_b(rst_b),
    .request(softReset),
    .engineIdle(drainDone),
    .inProgress(rstInProgress),
    .engineReset(rstPulse),
    .done(rstDone)
  );

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      ackPending <= 1'b0;
    end
    else
    begin
      ackPending <= (read | write) & ~ackPending;
    end
  end

  always @*
  begin
    irqEvents = {`IRQ_WIDTH{1'b0}};
    irqEvents[`IRQ_HALTED] = ~halted & ~readRun & engineIdle;
    irqEvents[`IRQ_STARTED] = halted & readRun & ~rstInProgress;
    irqEvents[`IRQ_ERROR] = errorDetected;
    irqEvents[`IRQ_RESET_DONE] = rstDone;
  end

  // Run bit after this edge; data path follows it without a cycle of lag
  always @*
  begin
    next_readRun = readRun;
    if (wrCycle && address == `OFF_READ_CTRL && byteenable[0])
    begin
      next_readRun = writedata[`BIT_RUN];
    end
    // error forces stop, even over a write
    if (errorDetected)
    begin
      next_readRun = 1'b0;
    end
  end

  // Control and status registers
  always @(posedge clk)
  begin
    if (!rst_b || rstPulse)
    begin
      readRun <= CTRL_DEFAULT[`BIT_RUN];
      fixedAddr <= 1'b0;
      halted <= 1'b1;
      errorFlag <= 1'b0;
      writeCtrl <= `CTRL_RESET;
      directMode <= 1'b0;
      multiChannel <= 1'b0;
    end
    else
    begin
      readRun <= next_readRun;
      if (wrCycle && address == `OFF_READ_CTRL && byteenable[0])
      begin
        fixedAddr <= writedata[`BIT_FIXED_ADDR];
      end
      if (errorDetected)
      begin
        errorFlag <= 1'b1;
      end
      if (wrCycle && address == `OFF_WRITE_CTRL)
      begin
        writeCtrl <= (writeCtrl & ~laneMask(byteenable)) | wdata;
      end
      if (wrCycle && address == `OFF_CONFIG && byteenable[0])
      begin
        directMode <= writedata[`CFG_DIRECT];
        multiChannel <= writedata[`CFG_MULTI];
      end
      if (!readRun && engineIdle)
      begin
        halted <= 1'b1;
      end
      else if (readRun && !rstInProgress)
      begin
        halted <= 1'b0;
      end
    end
  end

  // Interrupt status and mask
  always @(posedge clk)
  begin
    if (!rst_b || rstPulse)
    begin
      irqStatus <= {`IRQ_WIDTH{1'b0}};
      irqMask <= {`IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      // Set wins over a simultaneous clear
      if (wrCycle && address == `OFF_IRQ_STATUS)
      begin
        irqStatus <= (irqStatus & ~wdata[`IRQ_WIDTH-1:0]) | irqEvents;
      end
      else
      begin
        irqStatus <= irqStatus | irqEvents;
      end
      if (wrCycle && address == `OFF_IRQ_MASK)
      begin
        irqMask <= (irqMask & ~laneBits[`IRQ_WIDTH-1:0]) | wdata[`IRQ_WIDTH-1:0];
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  // Data path steering
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      runEnable <= 1'b0;
      flushRequest <= 1'b0;
      readBurstType <= `BURST_INCR;
      engineReset <= 1'b0;
    end
    else
    begin
      runEnable <= next_readRun & ~softReset & ~rstInProgress & ~rstPulse;
      // flush pending; stream may be cut
      flushRequest <= (~readRun | rstInProgress) & ~halted;
      // fixed bursts only where it applies
      readBurstType <= (fixedAddr && !directMode && !multiChannel) ? `BURST_FIXED
        : `BURST_INCR;
      engineReset <= rstPulse;
    end
  end

  // Register read mux
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      readdata <= 32'h0000_0000;
    end
    else if (read && !ackPending)
    begin
      case (address)
        `OFF_READ_CTRL:
        begin
          readdata <= 32'h0000_0000;
          readdata[`BIT_RUN] <= readRun;
          readdata[`BIT_RSVD_ONE] <= 1'b1;
          readdata[`BIT_SOFT_RESET] <= rstInProgress;
          readdata[`BIT_FIXED_ADDR] <= fixedAddr;
        end
        `OFF_READ_STAT:
        begin
          readdata <= 32'h0000_0000;
          readdata[`BIT_HALTED] <= halted;
          readdata[`BIT_IDLE] <= engineIdle;
          readdata[`BIT_ERROR] <= errorFlag;
        end
        `OFF_WRITE_CTRL:
          readdata <= (writeCtrl & ~32'h0000_0004) | {29'h0, rstInProgress, 2'h2};
        `OFF_IRQ_STATUS:
          readdata <= {{(32-`IRQ_WIDTH){1'b0}}, irqStatus};
        `OFF_IRQ_MASK:
          readdata <= {{(32-`IRQ_WIDTH){1'b0}}, irqMask};
        `OFF_CONFIG:
          readdata <= {30'h0, multiChannel, directMode};
        default:
          readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### verif/memory_to_stream_channel_control_chk.sv
// Port checker for the read channel control block
`timescale 1ns/1ps
`include "memory_to_stream_ctrl_defs.vh"
module memory_to_stream_channel_control_chk
(
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register bus
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Engine side
  input wire engineBusy,
  input wire errorDetected,
  input wire writeChanReset,
  input wire runEnable,
  input wire engineReset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire ctlWr = write && !waitrequest && address == `OFF_READ_CTRL && byteenable[0];
  property p_err;
    errorDetected |=> !runEnable;
  endproperty
  a_err: assert property (p_err)
    else $error("run kept after error");
  property p_start;
    $rose(runEnable) |-> $past(ctlWr && writedata[`BIT_RUN]);
  endproperty
  a_start: assert property (p_start)
    else $error("run rose without write");
  property p_stop;
    ctlWr && !writedata[`BIT_RUN] |=> !runEnable;
  endproperty
  a_stop: assert property (p_stop)
    else $error("run kept after stop write");
  property p_rsvd;
    read && !waitrequest && address == `OFF_READ_CTRL |-> readdata[`BIT_RSVD_ONE];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read 0");
  property p_hold;
    $rose(engineReset) |-> engineReset[*8] ##1 !engineReset;
  endproperty
  a_hold: assert property (p_hold)
    else $error("engine reset not 8 cycles");
  property p_idle;
    $rose(engineReset) |-> $past(!engineBusy);
  endproperty
  a_idle: assert property (p_idle)
    else $error("reset while busy");
  property p_chan;
    writeChanReset |-> ##[1:300] engineReset;
  endproperty
  a_chan: assert property (p_chan)
    else $error("other channel reset ignored");
  property p_def;
    $fell(engineReset) |-> !runEnable;
  endproperty
  a_def: assert property (p_def)
    else $error("run set after soft reset");
endmodule
bind memory_to_stream_channel_control memory_to_stream_channel_control_chk i_chk (.clk, .rst_b, .address, .read,
  .write, .writedata, .readdata, .waitrequest, .engineBusy, .errorDetected, .writeChanReset,
  .runEnable, .engineReset, .byteenable);

// ### verif/engine_model.sv
// Data path stand-in: memory reads feeding the stream target
`timescale 1ns/1ps
module engine_model
(
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire runEnable,
  input wire flushRequest,
  input wire engineReset,
  // State
  output wire engineBusy,
  output wire descUpdatePending
);
  reg [4:0] opLeft;
  reg [1:0] wbLeft;
  reg slow;
  assign engineBusy = opLeft != 5'h0;
  assign descUpdatePending = wbLeft != 2'h0;
  always @(posedge clk)
  begin
    if (!rst_b || engineReset)
    begin
      opLeft <= 5'h0;
      wbLeft <= 2'h0;
      slow <= 1'b0;
    end
    else
    begin
      if (flushRequest && opLeft > 5'h2)
        opLeft <= 5'h2;
      else if (opLeft != 5'h0)
        opLeft <= opLeft - 5'h1;
      else if (runEnable)
      begin
        // Alternate prompt and slow operations
        opLeft <= slow ? 5'h13 : 5'h3;
        slow <= !slow;
      end
      if (opLeft == 5'h1)
        wbLeft <= 2'h3;
      else if (wbLeft != 2'h0)
        wbLeft <= wbLeft - 2'h1;
    end
  end
endmodule

// ### verif/memory_to_stream_channel_control_tb.sv
// Self-checking bench for the read channel control block
`timescale 1ns/1ps
`include "memory_to_stream_ctrl_defs.vh"
module memory_to_stream_channel_control_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] address = 8'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0000_0000;
  reg [3:0] byteenable = 4'hf;
  reg errorDetected = 1'b0;
  reg writeChanReset = 1'b0;
  wire [31:0] readdata;
  wire waitrequest, engineBusy, descUpdatePending, runEnable, flushRequest, engineReset, irq;
  wire [1:0] readBurstType;
  integer errorCnt = 0;
  integer totalChecks = 0;
  integer i;
  reg [7:0] randAddr;
  reg [63:0] note;
  reg [63:0] expQ[$];
  memory_to_stream_channel_control i_dut (.clk, .rst_b, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .engineBusy, .descUpdatePending, .errorDetected, .writeChanReset,
    .runEnable, .flushRequest, .readBurstType, .engineReset, .irq);
  engine_model i_eng (.clk, .rst_b, .runEnable, .flushRequest, .engineReset, .engineBusy,
    .descUpdatePending);
  initial
  begin
    forever #4 clk = ~clk;
  end
  task report_and_stop;
  begin
    if (errorCnt == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    totalChecks = totalChecks + 1;
    if (got !== exp)
    begin
      errorCnt = errorCnt + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Reads note the expected value and mask; the monitor compares
  task bus(input wr, input [7:0] a, input [31:0] d, input [31:0] m);
  begin
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    if (!wr)
      expQ.push_back({m, d});
    @(posedge clk);
    while (waitrequest)
      @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  end
  endtask
  // Engine reset may already be up when called
  task wait_reset;
  begin
    while (!engineReset)
      @(posedge clk);
    while (engineReset)
      @(posedge clk);
  end
  endtask
  always @(posedge clk)
  begin
    if (read && !waitrequest)
    begin
      note = expQ.pop_front();
      chk(readdata & note[63:32], note[31:0] & note[63:32]);
    end
  end
  initial
  begin
    i = $urandom(32'h93ad);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, `OFF_READ_CTRL, `CTRL_RESET, 32'hffff_ffff);
    chk(readBurstType, `BURST_INCR);
    // set while idle; short bursts, no realignment
    bus(1, `OFF_READ_CTRL, 32'h0000_0008, 0);
    bus(0, `OFF_READ_CTRL, 32'h0000_000a, 32'hffff_ffff);
    chk(readBurstType, `BURST_FIXED);
    for (i = 1; i < 3; i = i + 1)
    begin
      bus(1, `OFF_CONFIG, i, 0);
      repeat (2) @(posedge clk);
      chk(readBurstType, `BURST_INCR);
    end
    bus(1, `OFF_CONFIG, 0, 0);
    bus(1, `OFF_READ_CTRL, 32'h0000_0001, 0);
    @(posedge clk);
    chk(runEnable, 1);
    repeat (3) @(posedge clk);
    bus(0, `OFF_READ_STAT, 0, 32'h0000_0001);
    bus(1, `OFF_READ_CTRL, 0, 0);
    @(posedge clk);
    chk(runEnable, 0);
    while (engineBusy || descUpdatePending) @(posedge clk);
    repeat (2) @(posedge clk);
    bus(0, `OFF_READ_STAT, 32'h0000_0001, 32'h0000_0001);
    bus(1, `OFF_IRQ_MASK, 32'h0000_0000, 0);
    bus(1, `OFF_IRQ_STATUS, 32'h0000_000f, 0);
    bus(1, `OFF_READ_CTRL, 32'h0000_0001, 0);
    @(posedge clk) errorDetected <= 1'b1;
    @(posedge clk) errorDetected <= 1'b0;
    @(negedge clk) chk(runEnable, 0);
    chk(irq, 0);
    bus(0, `OFF_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
    bus(1, `OFF_IRQ_MASK, 32'h0000_0004, 0);
    repeat (2) @(negedge clk);
    chk(irq, 1);
    bus(1, `OFF_IRQ_STATUS, 32'h0000_0004, 0);
    repeat (2) @(negedge clk);
    chk(irq, 0);
    bus(1, `OFF_READ_CTRL, 32'h0000_0005, 0);
    bus(0, `OFF_READ_CTRL, 32'h0000_0004, 32'h0000_0004);
    wait_reset;
    bus(0, `OFF_READ_CTRL, `CTRL_RESET, 32'hffff_ffff);
    bus(1, `OFF_READ_CTRL, 32'h0000_0008, 0);
    @(posedge clk) writeChanReset <= 1'b1;
    @(posedge clk) writeChanReset <= 1'b0;
    wait_reset;
    chk(readBurstType, `BURST_INCR);
    bus(0, `OFF_READ_CTRL, `CTRL_RESET, 32'hffff_ffff);
    // Control bits sit in the low lane; a write without it is dropped
    byteenable <= 4'he;
    bus(1, `OFF_READ_CTRL, 32'h0000_000d, 0);
    byteenable <= 4'hf;
    bus(0, `OFF_READ_CTRL, `CTRL_RESET, 32'hffff_ffff);
    for (i = 0; i < 8; i = i + 1)
    begin
      randAddr = 8'h80 | 8'($urandom & 32'h0000_007c);
      bus(1, randAddr, $urandom, 0);
      bus(0, randAddr, 0, 32'hffff_ffff);
    end
    report_and_stop;
  end
  initial
  begin
    #(8 * 20000);
    errorCnt = errorCnt + 1;
    report_and_stop;
  end
endmodule
